//--- hdl/sps_pkg.sv
// package: constants, state type and decode functions of the phase sequencer
package sps_pkg;

    // -------------------------------------------------------------------------
    // sequencer states (gray coded along the clockwise half-step path)
    // -------------------------------------------------------------------------
    typedef enum logic [2:0] {
        SPS_S1 = 3'h0,
        SPS_S2 = 3'h1,
        SPS_S3 = 3'h3,
        SPS_S4 = 3'h2,
        SPS_S5 = 3'h6,
        SPS_S6 = 3'h7,
        SPS_S7 = 3'h5,
        SPS_S8 = 3'h4
    } sps_state_t;

    localparam logic [2:0] SPS_STRIDE_HALF = 3'h1;
    localparam logic [2:0] SPS_STRIDE_FULL = 3'h2;

    // -------------------------------------------------------------------------
    // protection thresholds
    // -------------------------------------------------------------------------
    localparam int         SPS_CUR_W        = 12;
    localparam int         SPS_TEMP_W       = 8;
    localparam logic [11:0] SPS_OC_THRESH_MA = 12'hAF0;
    localparam logic [7:0] SPS_TSD_LIMIT_C  = 8'hA5;
    localparam logic [7:0] SPS_TSD_HYST_C   = 8'h0F;
    localparam logic [7:0] SPS_TSD_RESUME_C = 8'(SPS_TSD_LIMIT_C - SPS_TSD_HYST_C);

    // -------------------------------------------------------------------------
    // register map
    // -------------------------------------------------------------------------
    localparam int         SPS_ADDR_W     = 4;
    localparam int         SPS_DATA_W     = 8;
    localparam logic [3:0] SPS_OFF_STATUS = 4'h0;
    localparam logic [3:0] SPS_OFF_IRQ_EN = 4'h4;
    localparam logic [3:0] SPS_OFF_CLEAR  = 4'h8;
    localparam logic [3:0] SPS_OFF_STATE  = 4'hC;
    localparam int         SPS_EV_W       = 3;
    localparam int         SPS_EV_OC      = 0;
    localparam int         SPS_EV_THERM   = 1;
    localparam int         SPS_EV_STEP    = 2;
    localparam logic [2:0] SPS_EV_RST     = 3'h0;
    localparam logic [7:0] SPS_DATA_RST   = 8'h00;

    // -------------------------------------------------------------------------
    // state to position index and back
    // -------------------------------------------------------------------------
    function automatic logic [2:0] sps_idx(input sps_state_t s);
        return s ^ (s >> 1) ^ (s >> 2);
    endfunction : sps_idx

    function automatic sps_state_t sps_state(input logic [2:0] i);
        return sps_state_t'(i ^ (i >> 1));
    endfunction : sps_state

    // drive pattern {phase_a, phase_b, enable_a, enable_b}
    function automatic logic [3:0] sps_drive(input sps_state_t s);
        case (s)
            SPS_S1:  return 4'hF;
            SPS_S2:  return 4'h5;
            SPS_S3:  return 4'h7;
            SPS_S4:  return 4'h2;
            SPS_S5:  return 4'h3;
            SPS_S6:  return 4'h1;
            SPS_S7:  return 4'hB;
            default: return 4'hA;
        endcase
    endfunction : sps_drive

endpackage : sps_pkg

//--- hdl/sps_protect.sv
// module: overcurrent and thermal fault latches with open-drain enable pull-down
`timescale 1ns/1ps
module sps_protect (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    // sensed quantities
    input  wire logic [sps_pkg::SPS_CUR_W-1:0]  hs_current_ma,
    input  wire logic [sps_pkg::SPS_TEMP_W-1:0] die_temp_c,
    // shared enable line
    input  wire logic                      en_line_in,
    output logic                           en_line_out,
    output logic                           en_line_oe,
    // fault state
    output logic                           oc_fault,
    output logic                           therm_fault
);
    import sps_pkg::*;

    logic oc_reg;
    logic oc_next;
    logic therm_reg;
    logic therm_next;

    // -------------------------------------------------------------------------
    // fault latches
    // -------------------------------------------------------------------------
    always_comb begin
        oc_next = oc_reg;
        if (hs_current_ma >= SPS_OC_THRESH_MA) begin
            oc_next = 1'b1;
        end else if (!en_line_in) begin
            oc_next = 1'b0; // release once current is below threshold while the enable line is low
        end
        therm_next = therm_reg;
        if (die_temp_c >= SPS_TSD_LIMIT_C) begin
            therm_next = 1'b1;
        end else if (die_temp_c <= SPS_TSD_RESUME_C) begin
            therm_next = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            oc_reg    <= 1'b0;
            therm_reg <= 1'b0;
        end else begin
            oc_reg    <= oc_next;
            therm_reg <= therm_next;
        end
    end

    // -------------------------------------------------------------------------
    // one shared open-drain pull-down for both faults
    // -------------------------------------------------------------------------
    assign en_line_out = 1'b0;
    assign en_line_oe  = oc_reg | therm_reg;
    assign oc_fault    = oc_reg;
    assign therm_fault = therm_reg;

endmodule : sps_protect

//--- hdl/sps_top.sv
// module: eight-state stepper phase sequencer with protection and registers
//
// Operation
// - state advances only on a rising edge of the step pulse
// - sequence reset input forces state 1
// - after power-up the sequencer starts in state 1
// - direction high steps ascending, low steps descending
// - step size select high gives half-step through all eight states
// - half-step order 1..8 clockwise, 1,8,7..2 counterclockwise, wrapping
// - full-step from odd state: 1,3,5,7 or 1,7,5,3, two per pulse
// - full-step from even state: 2,4,6,8 or 8,6,4,2, two per pulse
// - half-step pulse from state 1 goes to 2 clockwise, 8 otherwise
// - phase and enable of both bridges come from the current state
// - high-side current at threshold raises an overcurrent fault
// - overcurrent pulls enable line low; resume when line returns high
// - thermal limit switches outputs off; resume after hysteresis drop
// - both faults act through the same enable-line pull-down
`timescale 1ns/1ps
module sps_top (
    // clock and reset
    input  wire logic                           clk,
    input  wire logic                           sys_rst,
    // controller inputs
    input  wire logic                           step_pulse,
    input  wire logic                           rotation_direction,
    input  wire logic                           half_step_sel,
    input  wire logic                           seq_reset,
    // sensed quantities
    input  wire logic [sps_pkg::SPS_CUR_W-1:0]  hs_current_ma,
    input  wire logic [sps_pkg::SPS_TEMP_W-1:0] die_temp_c,
    // shared enable line (open drain)
    input  wire logic                           en_line_in,
    output logic                                en_line_out,
    output logic                                en_line_oe,
    // bridge drive
    output logic                                phase_a,
    output logic                                phase_b,
    output logic                                bridge_en_a,
    output logic                                bridge_en_b,
    // register port
    input  wire logic [sps_pkg::SPS_ADDR_W-1:0] reg_addr,
    input  wire logic [sps_pkg::SPS_DATA_W-1:0] reg_wdata,
    input  wire logic                           reg_wr,
    input  wire logic                           reg_rd,
    output logic [sps_pkg::SPS_DATA_W-1:0]      reg_rdata,
    // interrupt
    output logic                                irq
);
    import sps_pkg::*;

    sps_state_t            state_reg;
    sps_state_t            state_next;
    logic                  step_prev_reg;
    logic                  step_rise;
    logic [2:0]            stride;
    logic [2:0]            cur_idx;
    logic                  oc_fault;
    logic                  therm_fault;
    logic                  drive_ok;
    logic [3:0]            drive_reg;
    logic [3:0]            drive_next;
    logic                  oc_prev_reg;
    logic                  therm_prev_reg;
    logic [SPS_EV_W-1:0]   events;
    logic [SPS_EV_W-1:0]   status_reg;
    logic [SPS_EV_W-1:0]   status_next;
    logic [SPS_EV_W-1:0]   irq_en_reg;
    logic [SPS_EV_W-1:0]   irq_en_next;
    logic [SPS_EV_W-1:0]   clr_mask;
    logic [SPS_DATA_W-1:0] rdata_reg;
    logic [SPS_DATA_W-1:0] rdata_next;

    // -------------------------------------------------------------------------
    // protection
    // -------------------------------------------------------------------------
    sps_protect u_protect (
        .clk           (clk),
        .sys_rst       (sys_rst),
        .hs_current_ma (hs_current_ma),
        .die_temp_c    (die_temp_c),
        .en_line_in    (en_line_in),
        .en_line_out   (en_line_out),
        .en_line_oe    (en_line_oe),
        .oc_fault      (oc_fault),
        .therm_fault   (therm_fault)
    );

    // -------------------------------------------------------------------------
    // phase sequencer
    // -------------------------------------------------------------------------
    assign step_rise = step_pulse & ~step_prev_reg;
    assign cur_idx   = sps_idx(state_reg);

    always_comb begin
        // full-step keeps odd or even parity because the stride is two
        stride     = half_step_sel ? SPS_STRIDE_HALF : SPS_STRIDE_FULL;
        state_next = state_reg;
        if (seq_reset) begin
            state_next = SPS_S1;
        end else if (step_rise) begin
            if (rotation_direction) begin
                state_next = sps_state(3'(cur_idx + stride));
            end else begin
                state_next = sps_state(3'(cur_idx - stride));
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg     <= SPS_S1;
            step_prev_reg <= 1'b1;
        end else begin
            state_reg     <= state_next;
            step_prev_reg <= step_pulse;
        end
    end

    // -------------------------------------------------------------------------
    // bridge drive
    // -------------------------------------------------------------------------
    assign drive_ok = en_line_in & ~oc_fault & ~therm_fault;

    always_comb begin
        drive_next = sps_drive(state_reg);
        if (!drive_ok) begin
            drive_next[1:0] = 2'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            drive_reg <= 4'h0;
        end else begin
            drive_reg <= drive_next;
        end
    end

    assign phase_a     = drive_reg[3];
    assign phase_b     = drive_reg[2];
    assign bridge_en_a = drive_reg[1];
    assign bridge_en_b = drive_reg[0];

    // -------------------------------------------------------------------------
    // interrupt status and registers
    // -------------------------------------------------------------------------
    assign events[SPS_EV_OC]    = oc_fault & ~oc_prev_reg;
    assign events[SPS_EV_THERM] = therm_fault & ~therm_prev_reg;
    assign events[SPS_EV_STEP]  = step_rise & ~seq_reset;

    always_comb begin
        clr_mask = '0;
        if (reg_wr && reg_addr == SPS_OFF_CLEAR) begin
            clr_mask = reg_wdata[SPS_EV_W-1:0];
        end
        // a new event wins over a clear in the same cycle
        status_next = (status_reg & ~clr_mask) | events;
        irq_en_next = irq_en_reg;
        if (reg_wr && reg_addr == SPS_OFF_IRQ_EN) begin
            irq_en_next = reg_wdata[SPS_EV_W-1:0];
        end
        rdata_next = SPS_DATA_RST;
        if (reg_rd) begin
            case (reg_addr)
                SPS_OFF_STATUS: rdata_next = {5'h00, status_reg};
                SPS_OFF_IRQ_EN: rdata_next = {5'h00, irq_en_reg};
                SPS_OFF_STATE:  rdata_next = {en_line_in, therm_fault, oc_fault,
                                              rotation_direction, half_step_sel,
                                              cur_idx};
                default:        rdata_next = SPS_DATA_RST;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            status_reg     <= SPS_EV_RST;
            irq_en_reg     <= SPS_EV_RST;
            rdata_reg      <= SPS_DATA_RST;
            oc_prev_reg    <= 1'b0;
            therm_prev_reg <= 1'b0;
        end else begin
            status_reg     <= status_next;
            irq_en_reg     <= irq_en_next;
            rdata_reg      <= rdata_next;
            oc_prev_reg    <= oc_fault;
            therm_prev_reg <= therm_fault;
        end
    end

    assign reg_rdata = rdata_reg;
    assign irq       = |(status_reg & irq_en_reg);

    // -------------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_quiet;
        !step_rise && !seq_reset;
    endsequence

    sequence s_half_step;
        step_rise && half_step_sel && !seq_reset;
    endsequence

    sequence s_full_step;
        step_rise && !half_step_sel && !seq_reset;
    endsequence

    // reset, two quiet cycles, then one half step, as the controller orders wave entry
    sequence s_wave_entry;
        seq_reset ##1 s_quiet[*2] ##1 s_half_step;
    endsequence

    AST_HOLD_WITHOUT_EDGE: assert property (
        s_quiet |=> state_reg == $past(state_reg))
        else $error("state moved without a step edge");

    AST_SEQ_RESET_S1: assert property (
        seq_reset |=> state_reg == SPS_S1)
        else $error("sequence reset did not give state 1");

    AST_POWER_UP_S1: assert property (
        disable iff (1'b0) $past(sys_rst) |-> state_reg == SPS_S1)
        else $error("state after system reset is not state 1");

    AST_HALF_CW: assert property (
        s_half_step and rotation_direction
        |=> sps_idx(state_reg) == 3'($past(cur_idx) + SPS_STRIDE_HALF))
        else $error("half-step clockwise order wrong");

    AST_HALF_CCW: assert property (
        s_half_step and !rotation_direction
        |=> sps_idx(state_reg) == 3'($past(cur_idx) - SPS_STRIDE_HALF))
        else $error("half-step counterclockwise order wrong");

    AST_FULL_ODD: assert property (
        s_full_step and !cur_idx[0] and rotation_direction
        |=> !cur_idx[0] && cur_idx == 3'($past(cur_idx) + SPS_STRIDE_FULL))
        else $error("normal full-step order wrong");

    AST_FULL_EVEN: assert property (
        s_full_step and cur_idx[0] and !rotation_direction
        |=> cur_idx[0] && cur_idx == 3'($past(cur_idx) - SPS_STRIDE_FULL))
        else $error("wave full-step order wrong");

    AST_WAVE_ENTRY_EVEN: assert property (
        s_wave_entry |=> cur_idx[0] && (state_reg == SPS_S2 || state_reg == SPS_S8))
        else $error("step from state 1 did not reach state 2 or 8");

    AST_DRIVE_PATTERN: assert property (
        // sampled reset keeps the release edge, where the drive flops still clear, out
        drive_ok && !sys_rst |=> {phase_a, phase_b, bridge_en_a, bridge_en_b}
                     == sps_drive($past(state_reg))
                     && (bridge_en_a & bridge_en_b) == !$past(cur_idx[0]))
        else $error("bridge pattern does not match state");

    AST_OC_DETECT: assert property (
        hs_current_ma >= SPS_OC_THRESH_MA |=> oc_fault && en_line_oe && !en_line_out)
        else $error("overcurrent did not pull the enable line");

    AST_THERM_SHUTDOWN: assert property (
        die_temp_c >= SPS_TSD_LIMIT_C |=> therm_fault && en_line_oe ##1 !bridge_en_a
                                          && !bridge_en_b)
        else $error("thermal limit did not switch outputs off");

    AST_THERM_HYST: assert property (
        therm_fault && die_temp_c > SPS_TSD_RESUME_C |=> therm_fault)
        else $error("thermal fault left before hysteresis");

    AST_LINE_LOW_OFF: assert property (
        !en_line_in and s_quiet |=> !bridge_en_a && !bridge_en_b
                                  && state_reg == $past(state_reg))
        else $error("bridges on or state lost with enable line low");

endmodule : sps_top

//--- verif/sps_ctrl_model.sv
// partner: controller model driving step, direction, mode and reset
`timescale 1ns/1ps
module sps_ctrl_model (
    // clock
    input  wire logic clk,
    // controller outputs
    output logic      step_pulse,
    output logic      rotation_direction,
    output logic      half_step_sel,
    output logic      seq_reset
);
    initial begin
        step_pulse         = 1'b0;
        rotation_direction = 1'b1;
        half_step_sel      = 1'b1;
        seq_reset          = 1'b0;
    end

    // one rising edge held for n samples, then n low samples
    task automatic slow_step(input int n);
        @(posedge clk) step_pulse <= 1'b1;
        repeat (n) @(posedge clk);
        step_pulse <= 1'b0;
        repeat (n) @(posedge clk);
    endtask : slow_step

    task automatic do_step();
        slow_step(1);
    endtask : do_step

    task automatic set_mode(input logic dir, input logic half);
        @(posedge clk);
        rotation_direction <= dir;
        half_step_sel      <= half;
    endtask : set_mode

    task automatic pulse_reset();
        @(posedge clk) seq_reset <= 1'b1;
        @(posedge clk) seq_reset <= 1'b0;
    endtask : pulse_reset

    // select low first, then reset: lands in odd state 1
    task automatic enter_normal(input logic dir);
        set_mode(dir, 1'b0);
        pulse_reset();
    endtask : enter_normal

    // reset, one half step, then select low: lands in an even state
    task automatic enter_wave(input logic dir);
        pulse_reset();
        set_mode(dir, 1'b1);
        do_step();
        set_mode(dir, 1'b0);
    endtask : enter_wave
endmodule : sps_ctrl_model

//--- verif/test_stepper_phase_sequencer.sv
// testbench: phase sequencer stepping, protection, registers and interrupt
`timescale 1ns/1ps
module test_stepper_phase_sequencer;
    import sps_pkg::*;
    logic        clk;
    logic        sys_rst;
    logic        step_pulse;
    logic        rotation_direction;
    logic        half_step_sel;
    logic        seq_reset;
    logic [11:0] hs_current_ma;
    logic [7:0]  die_temp_c;
    logic        ext_en;
    wire         en_line_in;
    logic        en_line_out;
    logic        en_line_oe;
    logic        phase_a;
    logic        phase_b;
    logic        bridge_en_a;
    logic        bridge_en_b;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic        irq;
    int          mismatches;
    int          check_count;
    int          cycles;
    logic [2:0]  pos;
    logic [7:0]  v;
    // expected {phase_a, phase_b, enable_a, enable_b} per position
    logic [3:0]  drv_tab [8] = '{4'hF, 4'h5, 4'h7, 4'h2, 4'h3, 4'h1, 4'hB, 4'hA};

    // pulled-up enable line: external driver and device pull-down
    assign en_line_in = ext_en & ~(en_line_oe & ~en_line_out);

    sps_ctrl_model ctl (.clk(clk), .step_pulse(step_pulse),
        .rotation_direction(rotation_direction), .half_step_sel(half_step_sel),
        .seq_reset(seq_reset));

    sps_top dut (.clk(clk), .sys_rst(sys_rst), .step_pulse(step_pulse),
        .rotation_direction(rotation_direction), .half_step_sel(half_step_sel),
        .seq_reset(seq_reset), .hs_current_ma(hs_current_ma), .die_temp_c(die_temp_c),
        .en_line_in(en_line_in), .en_line_out(en_line_out), .en_line_oe(en_line_oe),
        .phase_a(phase_a), .phase_b(phase_b), .bridge_en_a(bridge_en_a),
        .bridge_en_b(bridge_en_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        check_count++;
        if (seen !== want) begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    // STATE register and bridge drive must both show position p
    task automatic check_pos(input logic [2:0] p);
        logic [7:0] s;
        rd(SPS_OFF_STATE, s);
        check(s, {1'b1, 2'b00, rotation_direction, half_step_sel, p});
        check({4'h0, phase_a, phase_b, bridge_en_a, bridge_en_b}, {4'h0, drv_tab[p]});
    endtask : check_pos

    task automatic run_seq(input logic dir, input logic half, input int n);
        ctl.set_mode(dir, half);
        for (int i = 0; i < n; i++) begin
            ctl.do_step();
            pos = dir ? pos + (half ? 3'h1 : 3'h2) : pos - (half ? 3'h1 : 3'h2);
            check_pos(pos);
        end
    endtask : run_seq

    task automatic check_prot(input logic oe, input logic [7:0] status);
        repeat (3) @(posedge clk);
        #1;
        check({6'h00, en_line_oe, en_line_out}, {6'h00, oe, 1'b0});
        if (oe)
            check({6'h00, bridge_en_a, bridge_en_b}, 8'h00);
        rd(SPS_OFF_STATUS, v);
        check(v, status);
    endtask : check_prot

    initial begin
        sys_rst = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        hs_current_ma = 12'h000;
        die_temp_c = 8'h19;
        ext_en = 1'b1;
        mismatches = 0;
        check_count = 0;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        rd(SPS_OFF_STATUS, v);
        check(v, 8'h00);
        rd(SPS_OFF_IRQ_EN, v);
        check(v, 8'h00);
        pos = 3'h0;
        check_pos(pos);
        run_seq(1'b1, 1'b1, 9);
        ctl.pulse_reset();
        pos = 3'h0;
        check_pos(pos);
        run_seq(1'b0, 1'b1, 9);
        ctl.slow_step(6);
        pos = pos - 3'h1;
        check_pos(pos);
        ctl.enter_normal(1'b1);
        pos = 3'h0;
        run_seq(1'b1, 1'b0, 5);
        run_seq(1'b0, 1'b0, 5);
        ctl.enter_wave(1'b1);
        pos = 3'h1;
        check_pos(pos);
        run_seq(1'b1, 1'b0, 5);
        ctl.enter_wave(1'b0);
        pos = 3'h7;
        run_seq(1'b0, 1'b0, 5);
        @(posedge clk) ext_en <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check({4'h0, phase_a, phase_b, bridge_en_a, bridge_en_b},
              {4'h0, drv_tab[pos] & 4'hC});
        @(posedge clk) ext_en <= 1'b1;
        repeat (2) @(posedge clk);
        check_pos(pos);
        wr(SPS_OFF_CLEAR, 8'h07);
        wr(SPS_OFF_IRQ_EN, 8'h01);
        @(posedge clk) hs_current_ma <= 12'hAEF;
        check_prot(1'b0, 8'h00);
        @(posedge clk) hs_current_ma <= 12'hAF0;
        check_prot(1'b1, 8'h01);
        check({7'h00, irq}, 8'h01);
        @(posedge clk) hs_current_ma <= 12'h000;
        check_prot(1'b0, 8'h01);
        check_pos(pos);
        wr(SPS_OFF_CLEAR, 8'h01);
        check_prot(1'b0, 8'h00);
        check({7'h00, irq}, 8'h00);
        @(posedge clk) die_temp_c <= 8'hA5;
        check_prot(1'b1, 8'h02);
        check({7'h00, irq}, 8'h00);
        @(posedge clk) die_temp_c <= 8'h97;
        check_prot(1'b1, 8'h02);
        @(posedge clk) die_temp_c <= 8'h96;
        check_prot(1'b0, 8'h02);
        check_pos(pos);
        wr(SPS_OFF_STATUS, 8'hFF);
        rd(SPS_OFF_STATUS, v);
        check(v, 8'h02);
        rd(4'h2, v);
        check(v, 8'h00);
        rd(SPS_OFF_CLEAR, v);
        check(v, 8'h00);
        wr(SPS_OFF_IRQ_EN, 8'hFF);
        rd(SPS_OFF_IRQ_EN, v);
        check(v, 8'h07);
        check({7'h00, irq}, 8'h01);
        wr(SPS_OFF_CLEAR, 8'h02);
        #1 check({7'h00, irq}, 8'h00);
        summarize();
    end
endmodule : test_stepper_phase_sequencer
